// ==== rtl/bias_offset_pkg.sv ====
/*
 * Constants shared by the bias offset register bank and its testbench.
 * Assumes a single 40 MHz clock domain and AXI4-Lite byte addressing.
 */
// Function
// - Enabled accel correction adds each stored accel bias to its axis output.
// - Enabled rate correction adds the stored rate X bias to rate X output.
// - Each bias is four bytes forming one IEEE 754 single-precision value.
// - Bits 31:24 sit at the lowest byte address, bits 7:0 at highest.
// - Accel biases are in g, the same unit as the accel samples.
// - The rate bias is in degrees per second, like the rate samples.
// - Biases decode at 0x40, 0x44, 0x48 and 0x4C on page 0.
// - Every bias register resets to floating-point zero.
// - Every bias register can be saved to and restored from flash.
// - The host can read and write every byte of every bias.
// - Control bit 0 enables accel correction; cleared, accel biases are ignored.
// - Control bit 1 enables rate correction; cleared, rate biases are ignored.
package bias_offset_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h3C;
    localparam logic [7:0] ADDR_ACCEL_X = 8'h40;
    localparam logic [7:0] ADDR_ACCEL_Y = 8'h44;
    localparam logic [7:0] ADDR_ACCEL_Z = 8'h48;
    localparam logic [7:0] ADDR_RATE_X = 8'h4C;

    // ************************************************************
    // Register indices, shared by the bus and the flash image port
    // ************************************************************
    localparam logic [2:0] IDX_ACCEL_X = 3'h0;
    localparam logic [2:0] IDX_ACCEL_Y = 3'h1;
    localparam logic [2:0] IDX_ACCEL_Z = 3'h2;
    localparam logic [2:0] IDX_RATE_X = 3'h3;
    localparam logic [2:0] IDX_CONTROL = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam int NUM_OFFSETS = 4;
    localparam int NUM_ACCEL = 3;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    localparam int ACCEL_EN_BIT = 0;
    localparam int RATE_EN_BIT = 1;
    localparam int COMMIT_LANE = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/fp32_adder.sv ====
/*
 * Combinational single-precision adder used to apply a bias to a sample.
 * Assumes finite operands; infinity or NaN in the larger operand passes
 * through. Denormals flush to zero and the result is truncated.
 */
module fp32_adder (
    // Operands
    input wire logic [31:0] opA,
    input wire logic [31:0] opB,
    // Sum
    output logic [31:0] result
);

    logic bigIsA;
    logic [31:0] big;
    logic [31:0] lesser;
    logic [7:0] expDiff;
    logic [26:0] manBig;
    logic [26:0] manSmall;
    logic [26:0] manShift;
    logic [27:0] manSum;
    logic [27:0] manNorm;
    logic [4:0] lead;
    logic [9:0] expNorm;
    logic sameSign;
    logic underflow;
    logic overflow;

    assign bigIsA = opA[30:0] >= opB[30:0];
    assign big = bigIsA ? opA : opB;
    assign lesser = bigIsA ? opB : opA;
    assign expDiff = big[30:23] - lesser[30:23];
    assign manBig = (big[30:23] == 8'h00) ? 27'h000_0000 : {1'b1, big[22:0], 3'h0};
    assign manSmall = (lesser[30:23] == 8'h00) ? 27'h000_0000 : {1'b1, lesser[22:0], 3'h0};
    assign manShift = (expDiff > 8'h1A) ? 27'h000_0000 : (manSmall >> expDiff);
    assign sameSign = big[31] == lesser[31];
    assign manSum = sameSign ? ({1'b0, manBig} + {1'b0, manShift})
                             : ({1'b0, manBig} - {1'b0, manShift});

    // Position of the leading one; bit 26 is the normal hidden-bit place.
    always_comb begin
        lead = 5'h00;
        for (int i = 0; i < 28; i++) begin
            if (manSum[i]) begin
                lead = i[4:0];
            end
        end
    end

    assign manNorm = (lead == 5'h1B) ? (manSum >> 1) : (manSum << (5'h1A - lead));
    assign expNorm = {2'h0, big[30:23]} + {5'h00, lead} - 10'h01A;
    assign underflow = expNorm[9] || (expNorm == 10'h000);
    assign overflow = !expNorm[9] && (expNorm >= 10'h0FF);

    assign result = (big[30:23] == 8'hFF) ? big :
                    (manSum == 28'h000_0000) ? 32'h0000_0000 :
                    underflow ? {big[31], 31'h0000_0000} :
                    overflow ? {big[31], 8'hFF, 23'h00_0000} :
                    {big[31], expNorm[7:0], manNorm[25:3]};

endmodule

// ==== rtl/bias_offset_regs.sv ====
/*
 * Bias offset register bank with AXI4-Lite slave, sample correction path
 * and a flash image port. Assumes one clock, samples arriving as floats
 * from logic on the same clock, and an outside flash controller.
 */
module bias_offset_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // AXI4-Lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Raw samples
    input wire logic sampleValid,
    input wire logic [31:0] measAccelX,
    input wire logic [31:0] measAccelY,
    input wire logic [31:0] measAccelZ,
    input wire logic [31:0] measRateX,
    // Corrected samples
    output logic corrValid,
    output logic [31:0] corrAccelX,
    output logic [31:0] corrAccelY,
    output logic [31:0] corrAccelZ,
    output logic [31:0] corrRateX,
    // Flash image
    input wire logic restoreValid,
    input wire logic [2:0] restoreIndex,
    input wire logic [31:0] restoreData,
    input wire logic [2:0] backupIndex,
    output logic [31:0] backupData,
    input wire logic saveDone,
    output logic unsaved
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] byteSwap(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    function automatic logic [2:0] regIndex(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'h0};
        case (word)
            bias_offset_pkg::ADDR_ACCEL_X: return bias_offset_pkg::IDX_ACCEL_X;
            bias_offset_pkg::ADDR_ACCEL_Y: return bias_offset_pkg::IDX_ACCEL_Y;
            bias_offset_pkg::ADDR_ACCEL_Z: return bias_offset_pkg::IDX_ACCEL_Z;
            bias_offset_pkg::ADDR_RATE_X: return bias_offset_pkg::IDX_RATE_X;
            bias_offset_pkg::ADDR_CONTROL: return bias_offset_pkg::IDX_CONTROL;
            default: return bias_offset_pkg::IDX_NONE;
        endcase
    endfunction

    // Value byte j takes bus lane 3-j, so the lowest address holds bits 31:24.
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] busWord,
                                               input logic [3:0] strb);
        logic [31:0] swapped;
        logic [31:0] merged;
        swapped = byteSwap(busWord);
        merged = old;
        for (int j = 0; j < 4; j++) begin
            if (strb[3 - j]) begin
                merged[8 * j +: 8] = swapped[8 * j +: 8];
            end
        end
        return merged;
    endfunction

    // ************************************************************
    // Storage
    // ************************************************************
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic [31:0] stage_ff [bias_offset_pkg::NUM_OFFSETS];
    logic [31:0] active_ff [bias_offset_pkg::NUM_OFFSETS];
    logic [31:0] corr_ff [bias_offset_pkg::NUM_OFFSETS];
    logic corrValid_ff;
    logic [1:0] control_ff;
    logic [31:0] backupData_ff;
    logic unsaved_ff;
    logic firstCycle_ff;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic awFire;
    logic wFire;
    logic wrGo;
    logic [2:0] wIdx;
    logic wrMapped;
    logic arFire;
    logic [2:0] rdIdx;
    logic [31:0] rdWord;
    logic [1:0] nxt_control;
    logic nxt_unsaved;
    logic [31:0] backupWord;

    assign awFire = awvalid && awready_ff;
    assign wFire = wvalid && wready_ff;
    // Address and data may arrive in either order; the write fires once both are held.
    assign wrGo = !awready_ff && !wready_ff && !bvalid_ff;
    assign wIdx = regIndex(awAddr_ff);
    assign wrMapped = wIdx != bias_offset_pkg::IDX_NONE;
    assign arFire = arvalid && arready_ff;
    assign rdIdx = regIndex(araddr);
    assign rdWord = (rdIdx == bias_offset_pkg::IDX_CONTROL) ? {30'h0000_0000, control_ff} :
                    !rdIdx[2] ? byteSwap(stage_ff[rdIdx[1:0]]) : 32'h0000_0000;

    assign nxt_control = (restoreValid && restoreIndex == bias_offset_pkg::IDX_CONTROL) ?
                         restoreData[1:0] :
                         (wrGo && wIdx == bias_offset_pkg::IDX_CONTROL && wStrb_ff[0]) ?
                         wData_ff[1:0] : control_ff;
    // A mapped host write in the same cycle as saveDone keeps the flag set.
    assign nxt_unsaved = (wrGo && wrMapped) || (unsaved_ff && !saveDone);
    assign backupWord = (backupIndex == bias_offset_pkg::IDX_CONTROL) ?
                        {30'h0000_0000, control_ff} :
                        !backupIndex[2] ? active_ff[backupIndex[1:0]] : 32'h0000_0000;

    // ************************************************************
    // Bias words
    // ************************************************************
    logic [31:0] nxt_stage [bias_offset_pkg::NUM_OFFSETS];
    logic [31:0] nxt_active [bias_offset_pkg::NUM_OFFSETS];

    // The staged word takes bytes as they come; the applied word follows
    // only when the byte at the highest address lands, so the correction
    // never sees a half-updated float.
    always_comb begin
        logic restHit;
        logic hostHit;
        logic [31:0] merged;
        restHit = 1'b0;
        hostHit = 1'b0;
        merged = 32'h0000_0000;
        for (int i = 0; i < bias_offset_pkg::NUM_OFFSETS; i++) begin
            restHit = restoreValid && (restoreIndex == 3'(i));
            hostHit = wrGo && (wIdx == 3'(i));
            merged = mergeBytes(stage_ff[i], wData_ff, wStrb_ff);
            nxt_stage[i] = restHit ? restoreData : hostHit ? merged : stage_ff[i];
            nxt_active[i] = restHit ? restoreData :
                            (hostHit && wStrb_ff[bias_offset_pkg::COMMIT_LANE]) ?
                            merged : active_ff[i];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < bias_offset_pkg::NUM_OFFSETS; i++) begin
                stage_ff[i] <= bias_offset_pkg::OFFSET_RESET;
                active_ff[i] <= bias_offset_pkg::OFFSET_RESET;
            end
        end else begin
            for (int i = 0; i < bias_offset_pkg::NUM_OFFSETS; i++) begin
                stage_ff[i] <= nxt_stage[i];
                active_ff[i] <= nxt_active[i];
            end
        end
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= bias_offset_pkg::RESP_OKAY;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
        end else begin
            if (awFire) begin
                awready_ff <= 1'b0;
                awAddr_ff <= awaddr;
            end
            if (wFire) begin
                wready_ff <= 1'b0;
                wData_ff <= wdata;
                wStrb_ff <= wstrb;
            end
            if (wrGo) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wrMapped ? bias_offset_pkg::RESP_OKAY : bias_offset_pkg::RESP_SLVERR;
            end
            if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= bias_offset_pkg::RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (arFire) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rdWord;
            rresp_ff <= (rdIdx == bias_offset_pkg::IDX_NONE) ?
                        bias_offset_pkg::RESP_SLVERR : bias_offset_pkg::RESP_OKAY;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // ************************************************************
    // Control, flash image and status
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            control_ff <= bias_offset_pkg::CONTROL_RESET;
            unsaved_ff <= 1'b0;
            backupData_ff <= 32'h0000_0000;
            firstCycle_ff <= 1'b1;
        end else begin
            control_ff <= nxt_control;
            unsaved_ff <= nxt_unsaved;
            backupData_ff <= backupWord;
            firstCycle_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Correction path
    // ************************************************************
    logic [31:0] measIn [bias_offset_pkg::NUM_OFFSETS];
    logic [31:0] sumOut [bias_offset_pkg::NUM_OFFSETS];
    logic applyEn [bias_offset_pkg::NUM_OFFSETS];

    assign measIn[0] = measAccelX;
    assign measIn[1] = measAccelY;
    assign measIn[2] = measAccelZ;
    assign measIn[3] = measRateX;

    // Bias and sample share units (g, or degrees per second), so a plain
    // float add applies the correction without scaling.
    for (genvar ch = 0; ch < bias_offset_pkg::NUM_OFFSETS; ch++) begin : g_chan
        assign applyEn[ch] = (ch < bias_offset_pkg::NUM_ACCEL) ?
                             control_ff[bias_offset_pkg::ACCEL_EN_BIT] :
                             control_ff[bias_offset_pkg::RATE_EN_BIT];
        fp32_adder u_add (
            .opA(measIn[ch]),
            .opB(active_ff[ch]),
            .result(sumOut[ch])
        );
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            corrValid_ff <= 1'b0;
            for (int i = 0; i < bias_offset_pkg::NUM_OFFSETS; i++) begin
                corr_ff[i] <= 32'h0000_0000;
            end
        end else begin
            corrValid_ff <= sampleValid;
            for (int i = 0; i < bias_offset_pkg::NUM_OFFSETS; i++) begin
                if (sampleValid) begin
                    corr_ff[i] <= applyEn[i] ? sumOut[i] : measIn[i];
                end
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;
    assign corrValid = corrValid_ff;
    assign corrAccelX = corr_ff[0];
    assign corrAccelY = corr_ff[1];
    assign corrAccelZ = corr_ff[2];
    assign corrRateX = corr_ff[3];
    assign backupData = backupData_ff;
    assign unsaved = unsaved_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    resetZero_a:
    assert property (firstCycle_ff |-> active_ff[0] == 32'h0000_0000 &&
                     active_ff[3] == 32'h0000_0000 && stage_ff[1] == 32'h0000_0000)
    else $error("bias word not zero after reset");

    byteOrder_a:
    assert property (wrGo && wIdx == bias_offset_pkg::IDX_ACCEL_X && wStrb_ff == 4'hF &&
                     !restoreValid |=> stage_ff[0] == byteSwap($past(wData_ff)))
    else $error("bias bytes stored in wrong order");

    wholeWord_a:
    assert property (wrGo && wIdx == bias_offset_pkg::IDX_ACCEL_X && !wStrb_ff[3] &&
                     !restoreValid |=> $stable(active_ff[0]))
    else $error("applied bias changed on partial write");

    readBack_a:
    assert property (arFire && rdIdx == bias_offset_pkg::IDX_ACCEL_Y |=>
                     rvalid_ff && rdata_ff == byteSwap($past(stage_ff[1])))
    else $error("read data does not match stored bias");

    unmapped_a:
    assert property (arFire && rdIdx == bias_offset_pkg::IDX_NONE |=>
                     rresp_ff == bias_offset_pkg::RESP_SLVERR && rdata_ff == 32'h0000_0000)
    else $error("unmapped read not refused");

    accelOff_a:
    assert property (sampleValid && !control_ff[0] |=>
                     corrValid_ff && corr_ff[2] == $past(measAccelZ))
    else $error("accel bias applied while disabled");

    rateOff_a:
    assert property (sampleValid && !control_ff[1] |=> corr_ff[3] == $past(measRateX))
    else $error("rate bias applied while disabled");

    accelOn_a:
    assert property (sampleValid && control_ff[0] |=> corr_ff[0] == $past(sumOut[0]))
    else $error("accel output not corrected");

    rateOn_a:
    assert property (sampleValid && control_ff[1] && active_ff[3] == 32'h0000_0000 &&
                     measRateX[30:23] != 8'h00 |=> corr_ff[3] == $past(measRateX))
    else $error("zero rate bias altered the sample");

    restore_a:
    assert property (restoreValid && restoreIndex == bias_offset_pkg::IDX_ACCEL_Y |=>
                     active_ff[1] == $past(restoreData) ##1 ($past(backupIndex) != 3'h1 ||
                     backupData_ff == $past(active_ff[1])))
    else $error("flash restore or backup mismatch");

endmodule

// ==== tb/axil_host.sv ====
/*
 * AXI4-Lite host model: one write or one read under way at a time.
 * Assumes the bench checks the answers itself and bounds every wait.
 */
module axil_host (
    // Clock
    input wire logic mclk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both answer strobes stay high, so back-to-back calls never touch them twice per edge.
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
        bready = 1'b1;
        rready = 1'b1;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aDone;
        logic dDone;
        aDone = 1'b0;
        dDone = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aDone && dDone)) begin
            @(posedge mclk);
            if (awready && !aDone) begin
                aDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !dDone) begin
                dDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!bvalid);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
    endtask
endmodule

// ==== tb/bias_offset_regs_tb.sv ====
/*
 * Self-checking bench for the bias offset register bank.
 * Assumes the host model in axil_host and the package constants.
 */
module bias_offset_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] BASE = bias_offset_pkg::ADDR_ACCEL_X;
    localparam logic [7:0] CTRL = bias_offset_pkg::ADDR_CONTROL;
    localparam logic [1:0] OK = bias_offset_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = bias_offset_pkg::RESP_SLVERR;
    localparam logic [31:0] ONE = 32'h3F80_0000;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, restoreData, backupData;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic sampleValid, corrValid, restoreValid, saveDone, unsaved;
    logic [31:0] measAccelX, measAccelY, measAccelZ, measRateX;
    logic [31:0] corrAccelX, corrAccelY, corrAccelZ, corrRateX;
    logic [2:0] restoreIndex, backupIndex;
    logic [33:0] rdQ[$];
    logic [1:0] bQ[$];
    logic [127:0] cQ[$];
    logic [127:0] m;
    logic [31:0] v;
    logic [127:0] bias = {32'h3F80_0000, 32'h3F00_0000, 32'h4040_0000, 32'h4000_0000};
    int fails = 0;
    int compares = 0;
    int cyc = 0;

    bias_offset_regs dut_u (.*);
    axil_host host_u (.*);

    always #12.5 mclk = ~mclk;

    // ************************************************************
    // Helpers and result monitor
    // ************************************************************
    function automatic logic [31:0] bsw(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrx(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] r);
        bQ.push_back(r);
        host_u.wr(a, d, s);
    endtask

    task automatic rdx(logic [7:0] a, logic [33:0] e);
        rdQ.push_back(e);
        host_u.rd(a);
    endtask

    // Holds sampleValid up, so a run of calls gives back-to-back samples.
    task automatic smp(logic [127:0] mv, logic [127:0] e);
        cQ.push_back(e);
        sampleValid <= 1'b1;
        {measAccelX, measAccelY, measAccelZ, measRateX} <= mv;
        @(posedge mclk);
    endtask

    // A result that never came back leaves its note queued and counts as a mismatch.
    task automatic test_done();
        fails += cQ.size() + rdQ.size() + bQ.size();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge mclk) begin
        if (rvalid && rready) chk({rresp, rdata}, rdQ.pop_front(), "read");
        if (bvalid && bready) chk(bresp, bQ.pop_front(), "write response");
        if (corrValid) chk({corrAccelX, corrAccelY, corrAccelZ, corrRateX}, cQ.pop_front(), "sample");
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        {sampleValid, measAccelX, measAccelY, measAccelZ, measRateX} = '0;
        {restoreValid, restoreIndex, restoreData, backupIndex, saveDone} = '0;
        void'($urandom(78840));
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 4; i++) rdx(BASE + 8'(4 * i), {OK, 32'h0000_0000});
        rdx(CTRL, {OK, 32'h0000_0000});
        $display("Test reset values done");
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            wrx(BASE + 8'(4 * i), v, 4'hF, OK);
            rdx(BASE + 8'(4 * i), {OK, v});
        end
        wrx(8'h50, $urandom(), 4'hF, ERR);
        rdx(8'h50, {ERR, 32'h0000_0000});
        $display("Test read write and decode done");
        // Random biases stay in place here: any leak into the outputs would show.
        for (int i = 0; i < 4; i++) begin
            m = {$urandom(), $urandom(), $urandom(), $urandom()};
            smp(m, m);
        end
        sampleValid <= 1'b0;
        $display("Test correction disabled done");
        for (int i = 0; i < 4; i++) wrx(BASE + 8'(4 * i), bsw(bias[127 - 32 * i -: 32]), 4'hF, OK);
        for (int c = 1; c < 4; c++) begin
            wrx(CTRL, 32'(c), 4'h1, OK);
            rdx(CTRL, {OK, 32'(c)});
            m[127:32] = c[0] ? {32'h4000_0000, 32'h3FC0_0000, 32'h4080_0000} : {3{ONE}};
            m[31:0] = c[1] ? 32'h4040_0000 : ONE;
            smp({4{ONE}}, m);
            sampleValid <= 1'b0;
        end
        $display("Test correction enabled done");
        wrx(BASE, 32'h0000_003F, 4'h7, OK);
        rdx(BASE, {OK, 32'h0000_003F});
        smp({4{ONE}}, {32'h4000_0000, 32'h3FC0_0000, 32'h4080_0000, 32'h4040_0000});
        sampleValid <= 1'b0;
        wrx(BASE, 32'h0000_0000, 4'h8, OK);
        smp({4{ONE}}, {32'h3FC0_0000, 32'h3FC0_0000, 32'h4080_0000, 32'h4040_0000});
        sampleValid <= 1'b0;
        $display("Test whole word commit done");
        backupIndex <= bias_offset_pkg::IDX_ACCEL_X;
        repeat (3) @(posedge mclk);
        chk(backupData, 32'h3F00_0000, "backup word");
        chk(unsaved, 1'b1, "unsaved set");
        saveDone <= 1'b1;
        @(posedge mclk);
        saveDone <= 1'b0;
        @(posedge mclk);
        chk(unsaved, 1'b0, "unsaved cleared");
        restoreValid <= 1'b1;
        restoreIndex <= bias_offset_pkg::IDX_ACCEL_Y;
        restoreData <= 32'h4080_0000;
        backupIndex <= bias_offset_pkg::IDX_ACCEL_Y;
        @(posedge mclk);
        restoreValid <= 1'b0;
        rdx(BASE + 8'h04, {OK, bsw(32'h4080_0000)});
        chk(backupData, 32'h4080_0000, "backup restored");
        smp({4{ONE}}, {32'h3FC0_0000, 32'h40A0_0000, 32'h4080_0000, 32'h4040_0000});
        sampleValid <= 1'b0;
        $display("Test flash image done");
        // Let the last corrected sample reach the monitor before reset wipes it.
        @(posedge mclk);
        // A second reset in mid-run must bring back the floating-point zero.
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rdx(BASE + 8'h0C, {OK, 32'h0000_0000});
        $display("Test second reset done");
        repeat (4) @(posedge mclk);
        test_done();
    end
endmodule
